//--- core/srcb_pkg.sv
package srcb_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SRCB_CMD_OFF = 8'hb0;
    localparam logic [7:0] SRCB_DATA_OFF = 8'hb4;
    localparam logic [7:0] SRCB_IRQ_STAT_OFF = 8'hb8;
    localparam logic [7:0] SRCB_IRQ_MASK_OFF = 8'hbc;

    // ------------------------------------------------------------
    // Command register fields and reset values
    // ------------------------------------------------------------
    localparam int SRCB_BUSY_BIT = 31;
    localparam int SRCB_OP_LSB = 28;
    localparam int SRCB_OP_W = 3;
    localparam int SRCB_TO_BIT = 9;
    localparam int SRCB_ADDR_W = 8;
    localparam logic [7:0] SRCB_DATA_RST = 8'h00;
    localparam logic [1:0] SRCB_IRQ_RST = 2'h0;

    // Status bits: 0 op done, 1 op timeout
    localparam int SRCB_EV_DONE = 0;
    localparam int SRCB_EV_TO = 1;

    // Operation codes
    localparam logic [2:0] SRCB_OP_READ = 3'h0;
    localparam logic [2:0] SRCB_OP_WRITE = 3'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SRCB_CLK_MHZ = 200;
    localparam int SRCB_TIMEOUT_US = 30;
    localparam int SRCB_TIMEOUT_CYC = SRCB_TIMEOUT_US * SRCB_CLK_MHZ;
    localparam int SRCB_OP_CYC = 64;
    localparam int SRCB_MAC_BYTES = 6;

endpackage

//--- core/srcb_engine.sv
`timescale 1ns/1ps
module srcb_engine
    import srcb_pkg::*;
#(
    parameter int TIMEOUT_CYC = SRCB_TIMEOUT_CYC,
    parameter int OP_CYC = SRCB_OP_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Start and result
    input wire logic start,
    input wire logic rom_present,
    output logic done,
    output logic timed_out
);

    // ------------------------------------------------------------
    // Operation timer
    // ------------------------------------------------------------
    logic [31:0] cnt_q, cnt_d;
    logic run_q, run_d;
    logic done_d, to_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        to_d = 1'b0;
        if (start) begin
            run_d = 1'b1;
            cnt_d = 32'h0;
        end else if (run_q) begin
            cnt_d = cnt_q + 32'h1;
            if (rom_present && cnt_q == 32'(OP_CYC - 1)) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else if (cnt_q == 32'(TIMEOUT_CYC - 1)) begin
                run_d = 1'b0;
                done_d = 1'b1;
                to_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0;
            run_q <= 1'b0;
            done <= 1'b0;
            timed_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done <= done_d;
            timed_out <= to_d;
        end
    end

endmodule // srcb_engine

//--- core/srcb_top.sv
// What this block does
// - Writing busy one launches selected operation
// - Busy stays set until operation completes
// - Read data valid when busy clears
// - Absent ROM write clears on timeout
// - Busy set after reset during MAC load
// - Busy clears once MAC load ends
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module srcb_top
    import srcb_pkg::*;
#(
    parameter int TIMEOUT_CYC = SRCB_TIMEOUT_CYC,
    parameter int OP_CYC = SRCB_OP_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // ROM side
    input wire logic rom_present,
    input wire logic [7:0] rom_rdata,
    output logic [7:0] rom_wdata,
    output logic [2:0] rom_op,
    output logic [7:0] rom_addr,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic [1:0] pres_sync_q;
    logic [7:0] rd_s1_q, rd_s2_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pres_sync_q <= 2'h0;
            rd_s1_q <= 8'h00;
            rd_s2_q <= 8'h00;
        end else begin
            pres_sync_q <= {pres_sync_q[0], rom_present};
            rd_s1_q <= rom_rdata;
            rd_s2_q <= rd_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Operation engine
    // ------------------------------------------------------------
    logic eng_start, eng_done, eng_to;
    srcb_engine #(
        .TIMEOUT_CYC(TIMEOUT_CYC),
        .OP_CYC(OP_CYC)
    ) u_engine (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(eng_start),
        .rom_present(pres_sync_q[1]),
        .done(eng_done),
        .timed_out(eng_to)
    );

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SRCB_BOOT, SRCB_MAC, SRCB_IDLE, SRCB_OP} srcb_state_e;

    srcb_state_e st_q, st_d;
    logic [2:0] op_q, op_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic [2:0] mac_q, mac_d;
    logic to_q, to_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [31:0] rdata_d;
    logic irq_d;
    logic wr_cmd, wr_data;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign wr_cmd = reg_wr && hit(reg_addr, SRCB_CMD_OFF);
    assign wr_data = reg_wr && hit(reg_addr, SRCB_DATA_OFF);

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        addr_d = addr_q;
        data_d = data_q;
        mac_d = mac_q;
        to_d = to_q;
        eng_start = 1'b0;
        stat_d = stat_q;
        mask_d = mask_q;
        if (reg_wr && hit(reg_addr, SRCB_IRQ_STAT_OFF)) begin
            stat_d = stat_q & ~reg_wdata[1:0];
        end
        if (reg_wr && hit(reg_addr, SRCB_IRQ_MASK_OFF)) begin
            mask_d = reg_wdata[1:0];
        end
        case (st_q)
            SRCB_BOOT: begin
                eng_start = 1'b1;
                op_d = SRCB_OP_READ;
                addr_d = 8'h00;
                mac_d = 3'h0;
                st_d = SRCB_MAC;
            end
            SRCB_MAC: begin
                if (eng_done) begin
                    if (eng_to || mac_q == 3'(SRCB_MAC_BYTES - 1)) begin
                        st_d = SRCB_IDLE;
                    end else begin
                        mac_d = mac_q + 3'h1;
                        addr_d = addr_q + 8'h01;
                        eng_start = 1'b1;
                    end
                end
            end
            SRCB_IDLE: begin
                if (wr_data) begin
                    data_d = reg_wdata[7:0];
                end
                if (wr_cmd && reg_wdata[SRCB_BUSY_BIT]) begin
                    op_d = reg_wdata[SRCB_OP_LSB +: SRCB_OP_W];
                    addr_d = reg_wdata[SRCB_ADDR_W-1:0];
                    to_d = 1'b0;
                    eng_start = 1'b1;
                    st_d = SRCB_OP;
                end
            end
            SRCB_OP: begin
                if (eng_done) begin
                    st_d = SRCB_IDLE;
                    to_d = eng_to;
                    if (op_q == SRCB_OP_READ && !eng_to) begin
                        data_d = rd_s2_q;
                    end
                end
            end
            default: st_d = SRCB_BOOT;
        endcase
        // Set wins over clear
        if (st_q == SRCB_OP && eng_done) begin
            stat_d[SRCB_EV_DONE] = 1'b1;
            stat_d[SRCB_EV_TO] = stat_d[SRCB_EV_TO] | eng_to;
        end
        irq_d = |(stat_d & mask_d);
        rdata_d = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                SRCB_CMD_OFF: begin
                    rdata_d[SRCB_BUSY_BIT] = (st_q != SRCB_IDLE);
                    rdata_d[SRCB_OP_LSB +: SRCB_OP_W] = op_q;
                    rdata_d[SRCB_TO_BIT] = to_q;
                    rdata_d[SRCB_ADDR_W-1:0] = addr_q;
                end
                SRCB_DATA_OFF: rdata_d[7:0] = data_q;
                SRCB_IRQ_STAT_OFF: rdata_d[1:0] = stat_q;
                SRCB_IRQ_MASK_OFF: rdata_d[1:0] = mask_q;
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SRCB_BOOT;
            op_q <= SRCB_OP_READ;
            addr_q <= 8'h00;
            data_q <= SRCB_DATA_RST;
            mac_q <= 3'h0;
            to_q <= 1'b0;
            stat_q <= SRCB_IRQ_RST;
            mask_q <= SRCB_IRQ_RST;
            reg_rdata <= 32'h0;
            irq <= 1'b0;
            rom_op <= 3'h0;
            rom_addr <= 8'h00;
            rom_wdata <= 8'h00;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            mac_q <= mac_d;
            to_q <= to_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            reg_rdata <= rdata_d;
            irq <= irq_d;
            rom_op <= op_d;
            rom_addr <= addr_d;
            rom_wdata <= data_d;
        end
    end

endmodule // srcb_top

//--- verif/srcb_asserts.sv
`timescale 1ns/1ps
module srcb_asserts
    import srcb_pkg::*;
#(
    parameter int TIMEOUT_CYC = 40,
    parameter int OP_CYC = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // ROM side
    input wire logic [2:0] rom_op,
    input wire logic [7:0] rom_addr,
    // Interrupt
    input wire logic irq
);
    // ----
    // Age since launch or reset
    // ----
    localparam int IDLE = 6 * OP_CYC + TIMEOUT_CYC;
    logic [7:0] age_q;
    logic [7:0] age_d;
    logic [31:0] wd_q;
    logic rd_cmd;
    logic go;
    assign rd_cmd = reg_rd && reg_addr == SRCB_CMD_OFF;
    assign go = reg_wr && reg_addr == SRCB_CMD_OFF && reg_wdata[SRCB_BUSY_BIT];
    always_comb begin
        age_d = (age_q == 8'hff) ? age_q : age_q + 8'h01;
        if (go) begin
            age_d = 8'h00;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            age_q <= 8'h00;
            wd_q <= 32'h0;
        end else begin
            age_q <= age_d;
            wd_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside slot");
    a_busy_held: assert property (rd_cmd && age_q < OP_CYC |=> reg_rdata[31])
        else $error("busy dropped early");
    a_busy_ends: assert property (rd_cmd && age_q > IDLE |=> !reg_rdata[31])
        else $error("busy stuck");
    a_launch_seen: assert property (
        go && age_q > IDLE |=> rom_addr == wd_q[7:0] && rom_op == wd_q[30:28])
        else $error("launch not applied");
    a_cmd_layout: assert property (
        rd_cmd |=> reg_rdata[27:10] == 18'h0 && reg_rdata[8] == 1'b0)
        else $error("unused command bits set");
    a_irq_masked: assert property (
        reg_wr && reg_addr == SRCB_IRQ_MASK_OFF && reg_wdata[1:0] == 2'h0 |=> ##1 !irq)
        else $error("irq while masked");
endmodule // srcb_asserts
bind srcb_top srcb_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .OP_CYC(OP_CYC)) srcb_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rom_op(rom_op),
    .rom_addr(rom_addr), .irq(irq));

//--- verif/srcb_rom_model.sv
`timescale 1ns/1ps
module srcb_rom_model (
    // Clock and presence
    input wire logic clk_sys,
    input wire logic attach,
    // ROM pins
    input wire logic [7:0] rom_addr,
    output logic rom_present,
    output logic [7:0] rom_rdata
);
    // Floating bus toggles while detached
    logic [7:0] float_q = 8'h3c;
    always_ff @(posedge clk_sys) begin
        float_q <= ~float_q;
    end
    assign rom_present = attach;
    assign rom_rdata = attach ? (rom_addr ^ 8'ha5) : float_q;
endmodule // srcb_rom_model

//--- verif/serial_rom_command_busy_bench.sv
`timescale 1ns/1ps
module serial_rom_command_busy_bench
    import srcb_pkg::*;
();
    typedef struct packed {logic [2:0] op; logic [7:0] a; logic p; logic t; logic [7:0] d;} srcb_row_s;
    srcb_row_s rows [6] = '{'{SRCB_OP_READ, 8'h12, 1'b1, 1'b0, 8'hb7},
        '{SRCB_OP_WRITE, 8'h34, 1'b1, 1'b0, 8'hb7}, '{SRCB_OP_WRITE, 8'h56, 1'b0, 1'b1, 8'hb7},
        '{SRCB_OP_READ, 8'h78, 1'b0, 1'b1, 8'hb7}, '{3'h1, 8'h9a, 1'b1, 1'b0, 8'hb7},
        '{SRCB_OP_READ, 8'hff, 1'b1, 1'b0, 8'h5a}};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic attach = 1'b1;
    logic [31:0] reg_rdata, v;
    logic [7:0] rom_rdata, rom_addr, rom_wdata;
    logic rom_present, irq;
    int error_cnt = 0;
    int checked = 0;
    srcb_top #(.TIMEOUT_CYC(40), .OP_CYC(8)) srcb_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rom_present(rom_present), .rom_rdata(rom_rdata),
        .rom_wdata(rom_wdata), .rom_op(), .rom_addr(rom_addr), .irq(irq));
    srcb_rom_model srcb_rom_model_inst (.clk_sys(clk_sys), .attach(attach),
        .rom_addr(rom_addr), .rom_present(rom_present), .rom_rdata(rom_rdata));
    initial forever #2.5 clk_sys = ~clk_sys;
    // ----
    // Bus tasks and checks
    // ----
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        v = 32'hffff_ffff;
        while (v[31] !== 1'b0 && n < 200) begin
            rd(SRCB_CMD_OFF);
            n++;
        end
        if (v[31] !== 1'b0) begin
            error_cnt++;
            final_report;
        end else begin
            repeat (100) @(posedge clk_sys);
            rd(SRCB_CMD_OFF);
            chk({31'h0, v[31]}, 32'h0, "idle stays");
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(SRCB_CMD_OFF);
        chk({31'h0, v[31]}, 32'h1, "boot busy");
        wait_idle;
        rd(SRCB_IRQ_STAT_OFF);
        chk(v, {30'h0, SRCB_IRQ_RST}, "stat rst");
        $display("boot test done");
        foreach (rows[i]) begin
            attach <= rows[i].p;
            wr(SRCB_CMD_OFF, {1'b1, rows[i].op, 20'h0, rows[i].a});
            wait_idle;
            chk({31'h0, v[SRCB_TO_BIT]}, {31'h0, rows[i].t}, "timeout");
            rd(SRCB_DATA_OFF);
            chk({24'h0, v[7:0]}, {24'h0, rows[i].d}, "data");
        end
        $display("command rows done");
        wr(SRCB_DATA_OFF, 32'h0000_00c3);
        rd(SRCB_DATA_OFF);
        chk(v, 32'h0000_00c3, "data wr");
        chk({24'h0, rom_wdata}, 32'h0000_00c3, "rom wdata");
        $display("data test done");
        rd(SRCB_IRQ_STAT_OFF);
        chk(v, 32'h3, "status");
        wr(SRCB_IRQ_MASK_OFF, 32'h3);
        repeat (3) @(negedge clk_sys);
        chk({31'h0, irq}, 32'h1, "irq on");
        wr(SRCB_IRQ_STAT_OFF, 32'h3);
        repeat (3) @(negedge clk_sys);
        chk({31'h0, irq}, 32'h0, "irq clr");
        wr(SRCB_IRQ_MASK_OFF, 32'h0);
        rd(8'h40);
        chk(v, 32'h0, "unmapped");
        $display("irq test done");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(SRCB_CMD_OFF);
        chk({31'h0, v[31]}, 32'h1, "rerst busy");
        wait_idle;
        $display("reset test done");
        final_report;
    end
endmodule // serial_rom_command_busy_bench
